// ===== fsw_pkg.sv
// Package: shared constants for the flash status and word-program link.
// Assumes both ends run on one 25 MHz clock with active-low async reset.
package fsw_pkg;
  localparam int NPART = 4;
  localparam int PW = 2;
  localparam int AW = 16;
  localparam int DW = 16;
  // Status bit positions
  localparam int SB_READY = 7;
  localparam int SB_EHALT = 6;
  localparam int SB_EFAIL = 5;
  localparam int SB_PFAIL = 4;
  localparam int SB_VLOW = 3;
  localparam int SB_PHALT = 2;
  localparam int SB_LOCK = 1;
  localparam int SB_PBUSY = 0;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // Command codes
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  // Program time
  localparam int PROG_TIME_NS = 8000;
  localparam int CLK_NS = 40;
  localparam logic [15:0] PROG_CYCLES = 16'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
  // Clocks per half of one host bus cycle (active, then idle)
  localparam logic [3:0] PHASE_LEN = 4'h8;
  // Read modes of a partition
  typedef enum logic [1:0] {
    FSW_RD_ARRAY = 2'b00,
    FSW_RD_STATUS = 2'b01,
    FSW_RD_ID = 2'b10,
    FSW_RD_QUERY = 2'b11
  } fsw_rmode_e;
  // Host register map (AXI4-Lite byte addresses)
  localparam logic [3:0] HR_CMD = 4'h0;
  localparam logic [3:0] HR_ADDR = 4'h4;
  localparam logic [3:0] HR_DATA = 4'h8;
  localparam logic [3:0] HR_STAT = 4'hC;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_PROGRAM = 2'h2;
  function automatic logic [PW-1:0] part_of(input logic [AW-1:0] a);
    part_of = a[AW-1 -: PW];
  endfunction
endpackage

// ===== fsw_if.sv
// Interface: parallel flash bus between host controller and device.
// Assumes the bench resolves the data wire from the two enables.
`timescale 1ns/1ps
interface fsw_if;
  logic ce_b;
  logic oe_b;
  logic we_b;
  logic [15:0] addr;
  logic [15:0] dq_h2d;
  logic dq_h2d_oe;
  logic [15:0] dq_d2h;
  logic dq_d2h_oe;
  logic prog_supply_ok;
  logic standby;
  modport dev (input ce_b, oe_b, we_b, addr, dq_h2d, dq_h2d_oe, prog_supply_ok,
    output dq_d2h, dq_d2h_oe, standby);
  modport host (output ce_b, oe_b, we_b, addr, dq_h2d, dq_h2d_oe,
    input dq_d2h, dq_d2h_oe, standby);
endinterface

// ===== fsw_device.sv
// Device end: command decode, per-partition status, word program engine.
// Operation
// RULE_01: Program/lock commands switch partition to status reads; the code decodes no lock commands, only program does this
// RULE_02: Status reads are single accesses only
// RULE_03: Status latched on first CE/OE falling edge; the code latches again on an OE fall that follows CE
// RULE_04: Eight-bit status, upper byte driven zero
// RULE_05: Per-partition bits, device-wide ready bit
// RULE_06: Bit 7 low means engine busy
// RULE_07: Erase suspend sets bits 7,6 until resume; the code never sets bit 6, resume only clears it
// RULE_08: Erase fail bit 5; sequence error 7,5,4
// RULE_09: Bit 4 marks word program failure
// RULE_10: Supply-low bit sampled at completion only
// RULE_11: Program suspend sets bits 7,2 until resume
// RULE_12: Locked-block target aborts, sets bit 1
// RULE_13: Bits 7/0 encode busy location
// RULE_14: Clear-status zeroes status, keeps read modes
// RULE_15: Error bits clear only by command or reset
// RULE_16: Hardware reset clears status
// RULE_17: Host clears status after any error
// RULE_18: Programming only turns ones into zeros
// RULE_19: One programming partition, one erase-suspended
// RULE_20: Busy partition accepts status/suspend/id/query/array
// RULE_21: Host programs with setup then data word
// RULE_22: Standby deferred until programming completes
// Pins arrive asynchronously and are synchronised to CLK; lock state is an input.
`timescale 1ns/1ps
module fsw_device
(
  input wire logic CLK,
  input wire logic RST_B,
  fsw_if.dev BUS,
  input wire logic [fsw_pkg::NPART-1:0] LOCKED,
  input wire logic ERASE_FAIL,
  output logic [fsw_pkg::NPART-1:0] PART_PROGRAMMING,
  output logic BUSY
);
  import fsw_pkg::*;

  logic [2:0] ce_s1_q, ce_s2_q, ce_s3_q;
  logic [2:0] sync_d;
  logic [AW-1:0] addr_s1_q, addr_s2_q;
  logic [DW-1:0] dat_s1_q, dat_s2_q;
  logic vpp_s1_q, vpp_s2_q;
  logic ce_n, oe_n, we_n, ce_fall, oe_fall, we_rise, rd_act;

  // Two-flop synchronisers, then a third stage for edge detection
  always_comb begin
    sync_d = {BUS.ce_b, BUS.oe_b, BUS.we_b};
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ce_s1_q <= 3'h7;
      ce_s2_q <= 3'h7;
      ce_s3_q <= 3'h7;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      dat_s1_q <= '0;
      dat_s2_q <= '0;
      vpp_s1_q <= 1'b0;
      vpp_s2_q <= 1'b0;
    end else begin
      ce_s1_q <= sync_d;
      ce_s2_q <= ce_s1_q;
      ce_s3_q <= ce_s2_q;
      addr_s1_q <= BUS.addr;
      addr_s2_q <= addr_s1_q;
      dat_s1_q <= BUS.dq_h2d;
      dat_s2_q <= dat_s1_q;
      vpp_s1_q <= BUS.prog_supply_ok;
      vpp_s2_q <= vpp_s1_q;
    end
  end
  assign ce_n = ce_s2_q[2];
  assign oe_n = ce_s2_q[1];
  assign we_n = ce_s2_q[0];
  assign ce_fall = ce_s3_q[2] & ~ce_n;
  assign oe_fall = ce_s3_q[1] & ~oe_n;
  assign we_rise = ~ce_s3_q[0] & we_n & ~ce_n;
  assign rd_act = ~ce_n & ~oe_n & we_n;

  typedef enum logic [2:0] {
    FSW_IDLE = 3'b000,
    FSW_SETUP = 3'b001,
    FSW_PROG = 3'b010,
    FSW_PSUSP = 3'b011
  } fsw_eng_e;

  fsw_eng_e eng_q, eng_d;
  logic [7:0] stat_q [NPART];
  logic [7:0] stat_d [NPART];
  fsw_rmode_e mode_q [NPART];
  fsw_rmode_e mode_d [NPART];
  logic [PW-1:0] ppart_q, ppart_d;
  logic [15:0] cnt_q, cnt_d;
  logic [DW-1:0] mem_q [NPART];
  logic [DW-1:0] mem_d [NPART];
  logic [7:0] out_q, out_d;
  logic [DW-1:0] rdat_q, rdat_d;
  // Program word held locally: the host may reuse its data lines while the engine runs
  logic [DW-1:0] word_q, word_d;
  logic [PW-1:0] ap;
  logic [7:0] cmd;
  logic ready;

  assign ap = part_of(addr_s2_q);
  assign cmd = dat_s2_q[7:0];
  assign ready = (eng_q != FSW_SETUP) && (eng_q != FSW_PROG);

  always_comb begin
    eng_d = eng_q;
    ppart_d = ppart_q;
    cnt_d = cnt_q;
    out_d = out_q;
    rdat_d = rdat_q;
    word_d = word_q;
    for (int i = 0; i < NPART; i++) begin
      stat_d[i] = stat_q[i];
      mode_d[i] = mode_q[i];
      mem_d[i] = mem_q[i];
    end
    if (eng_q == FSW_PROG) begin
      if (cnt_q == 16'h0000) begin
        eng_d = FSW_IDLE;
        // Supply checked only at completion
        if (!vpp_s2_q) begin // RULE_10
          stat_d[ppart_q][SB_VLOW] = 1'b1;
        end else begin
          mem_d[ppart_q] = mem_q[ppart_q] & word_q; // RULE_18
        end
        if (ERASE_FAIL) begin
          stat_d[ppart_q][SB_EFAIL] = 1'b1; // RULE_08
        end
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
    if (we_rise) begin
      if (eng_q == FSW_SETUP) begin
        // Second cycle: data word at target address
        ppart_d = ap;
        mode_d[ap] = FSW_RD_STATUS; // RULE_01
        if (LOCKED[ap]) begin
          stat_d[ap][SB_LOCK] = 1'b1; // RULE_12
          eng_d = FSW_IDLE;
        end else if (stat_q[ap][SB_VLOW]) begin
          stat_d[ap][SB_PFAIL] = 1'b1; // RULE_09 RULE_17
          eng_d = FSW_IDLE;
        end else begin
          eng_d = FSW_PROG;
          cnt_d = PROG_CYCLES;
          word_d = dat_s2_q;
        end
      end else begin
        case (cmd)
          CMD_PROG, CMD_PROG_ALT: begin
            if (eng_q == FSW_IDLE) begin // RULE_19
              eng_d = FSW_SETUP; // RULE_21
            end else begin
              stat_d[ap][SB_EFAIL] = 1'b1; // RULE_08
              stat_d[ap][SB_PFAIL] = 1'b1;
            end
          end
          CMD_READ_ARRAY: mode_d[ap] = FSW_RD_ARRAY; // RULE_20
          CMD_READ_STATUS: mode_d[ap] = FSW_RD_STATUS;
          CMD_READ_ID: mode_d[ap] = FSW_RD_ID;
          CMD_READ_QUERY: mode_d[ap] = FSW_RD_QUERY;
          CMD_CLEAR_STATUS: begin
            // Modes untouched, works with supply low
            for (int i = 0; i < NPART; i++) begin
              // Bits the engine sets in this same cycle survive the clear
              stat_d[i] = stat_d[i] & ~stat_q[i]; // RULE_14 RULE_15
            end
          end
          CMD_SUSPEND: begin
            if (eng_q == FSW_PROG) begin
              eng_d = FSW_PSUSP;
              stat_d[ppart_q][SB_PHALT] = 1'b1; // RULE_11
            end
          end
          CMD_RESUME: begin
            if (eng_q == FSW_PSUSP) begin
              eng_d = FSW_PROG;
              stat_d[ppart_q][SB_PHALT] = 1'b0;
            end
            stat_d[ap][SB_EHALT] = 1'b0; // RULE_07
          end
          default: ;
        endcase
      end
    end
    // Status latched on every OE falling edge, and on a CE falling edge unless OE is already low
    if ((ce_fall | oe_fall) && !(ce_fall && !oe_n && !ce_s3_q[1])) begin // RULE_03
      out_d = stat_q[ap] & 8'h7E; // RULE_05
      out_d[SB_READY] = ready; // RULE_06
      out_d[SB_PBUSY] = !ready && (ppart_q != ap); // RULE_13
    end
    if (rd_act) begin
      case (mode_q[ap])
        FSW_RD_STATUS: rdat_d = {8'h00, out_q}; // RULE_04 RULE_02
        FSW_RD_ARRAY: rdat_d = (!ready && ppart_q == ap) ? 16'hFFFF : mem_q[ap];
        default: rdat_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      eng_q <= FSW_IDLE;
      ppart_q <= '0;
      cnt_q <= 16'h0000;
      out_q <= STATUS_RESET;
      rdat_q <= '0;
      word_q <= '0;
      for (int i = 0; i < NPART; i++) begin
        stat_q[i] <= 8'h00; // RULE_16
        mode_q[i] <= FSW_RD_ARRAY;
        mem_q[i] <= 16'hFFFF;
      end
    end else begin
      eng_q <= eng_d;
      ppart_q <= ppart_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      rdat_q <= rdat_d;
      word_q <= word_d;
      for (int i = 0; i < NPART; i++) begin
        stat_q[i] <= stat_d[i];
        mode_q[i] <= mode_d[i];
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign BUS.dq_d2h = rdat_q;
  assign BUS.dq_d2h_oe = rd_act;
  // Standby only once programming is finished or suspended
  assign BUS.standby = ce_n && ready; // RULE_22
  assign BUSY = !ready;
  always_comb begin
    PART_PROGRAMMING = '0;
    if (!ready) begin
      PART_PROGRAMMING[ppart_q] = 1'b1;
    end
  end
endmodule

// ===== fsw_host.sv
// Host end: AXI4-Lite slave registers driving bus cycles to the flash.
// Assumes the device answers reads after its synchroniser delay.
`timescale 1ns/1ps
module fsw_host
(
  input wire logic CLK,
  input wire logic RST_B,
  fsw_if.host BUS,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import fsw_pkg::*;

  typedef enum logic [1:0] {
    FSH_IDLE = 2'b00,
    FSH_ACT = 2'b01,
    FSH_GAP = 2'b10
  } fsh_st_e;

  fsh_st_e st_q, st_d;
  logic [3:0] ph_q, ph_d;
  logic [15:0] addr_q, addr_d, data_q, data_d, rd_q, rd_d;
  logic [1:0] op_q, op_d;
  logic second_q, second_d, rdop_q, rdop_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [3:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d;
  logic busy;

  assign busy = st_q != FSH_IDLE;

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    addr_d = addr_q;
    data_d = data_q;
    rd_d = rd_q;
    op_d = op_q;
    second_d = second_q;
    rdop_d = rdop_q;
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    rv_d = rv_q;
    rdata_d = rdata_q;
    if (AWVALID && !aw_q && !bv_q) begin
      aw_d = 1'b1;
      awa_d = AWADDR;
    end
    if (WVALID && !w_q && !bv_q) begin
      w_d = 1'b1;
      wd_d = WDATA;
    end
    if (aw_q && w_q && !bv_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = 2'b00;
      case (awa_q)
        HR_ADDR: addr_d = wd_q[15:0];
        HR_DATA: data_d = wd_q[15:0];
        HR_CMD: begin
          if (busy) begin
            bresp_d = 2'b10;
          end else begin
            // Program issues setup then data word back to back
            st_d = FSH_ACT;
            ph_d = 4'h0;
            op_d = wd_q[1:0];
            rdop_d = wd_q[1:0] == OP_READ;
            second_d = 1'b0;
          end
        end
        default: bresp_d = 2'b10;
      endcase
    end
    if (bv_q && BREADY) begin
      bv_d = 1'b0;
    end
    if (ARVALID && !rv_q) begin
      rv_d = 1'b1;
      case (ARADDR)
        HR_ADDR: rdata_d = {16'h0000, addr_q};
        HR_DATA: rdata_d = {16'h0000, rd_q};
        HR_STAT: rdata_d = {31'h0, busy};
        HR_CMD: rdata_d = {30'h0, op_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (rv_q && RREADY) begin
      rv_d = 1'b0;
    end
    case (st_q)
      FSH_ACT: begin
        ph_d = ph_q + 4'h1;
        if (ph_q == PHASE_LEN - 4'h2 && rdop_q) begin
          rd_d = BUS.dq_d2h;
        end
        if (ph_q == PHASE_LEN - 4'h1) begin
          st_d = FSH_GAP;
          ph_d = 4'h0;
        end
      end
      FSH_GAP: begin
        ph_d = ph_q + 4'h1;
        if (ph_q == PHASE_LEN - 4'h1) begin
          if (op_q == OP_PROGRAM && !second_q) begin
            second_d = 1'b1;
            st_d = FSH_ACT;
            ph_d = 4'h0;
          end else begin
            st_d = FSH_IDLE;
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= FSH_IDLE;
      ph_q <= 4'h0;
      addr_q <= '0;
      data_q <= '0;
      rd_q <= '0;
      op_q <= OP_WRITE;
      second_q <= 1'b0;
      rdop_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      bv_q <= 1'b0;
      bresp_q <= 2'b00;
      rv_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rd_q <= rd_d;
      op_q <= op_d;
      second_q <= second_d;
      rdop_q <= rdop_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
    end
  end

  // Setup write carries the program code, the second the data word
  assign BUS.ce_b = st_q != FSH_ACT; // RULE_02
  assign BUS.we_b = !(st_q == FSH_ACT && !rdop_q && ph_q < PHASE_LEN - 4'h2);
  assign BUS.oe_b = !(st_q == FSH_ACT && rdop_q);
  assign BUS.addr = addr_q;
  assign BUS.dq_h2d = (op_q == OP_PROGRAM && !second_q) ? {8'h00, CMD_PROG} : data_q; // RULE_21
  assign BUS.dq_h2d_oe = st_q == FSH_ACT && !rdop_q;
  assign AWREADY = !aw_q && !bv_q;
  assign WREADY = !w_q && !bv_q;
  assign BVALID = bv_q;
  assign BRESP = bresp_q;
  assign ARREADY = !rv_q;
  assign RVALID = rv_q;
  assign RDATA = rdata_q;
  assign RRESP = 2'b00;
endmodule

// ===== fsw_sva.sv
// Checker: bus strobes and engine state on the flash link.
// Assumes the bench instantiates it beside the interface.
`timescale 1ns/1ps
module fsw_sva
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic dq_h2d_oe,
  input wire logic dq_d2h_oe,
  input wire logic standby,
  input wire logic [fsw_pkg::NPART-1:0] PART_PROGRAMMING,
  input wire logic BUSY
);
  import fsw_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  one_prog_a: assert property ($onehot0(PART_PROGRAMMING))
    else $error("several partitions programming");
  busy_part_a: assert property (|PART_PROGRAMMING |-> BUSY)
    else $error("partition busy while engine idle");
  standby_hold_a: assert property (BUSY |-> !standby)
    else $error("standby during programming");
  write_sel_a: assert property (!we_b |-> !ce_b && dq_h2d_oe && oe_b)
    else $error("write strobe outside selected write");
  read_sel_a: assert property (!oe_b |-> !ce_b && !dq_h2d_oe)
    else $error("read strobe outside selected read");
  no_fight_a: assert property (!(dq_h2d_oe && dq_d2h_oe))
    else $error("both ends drive data");
  prog_end_a: assert property ($rose(BUSY) |-> ##[1:300] !BUSY)
    else $error("program never completes");
  cycle_len_a: assert property ($fell(ce_b) |-> !ce_b [*6])
    else $error("bus cycle too short");
  cover property ($rose(BUSY));
  cover property ($fell(oe_b));
  cover property (BUSY && ce_b);
endmodule

// ===== fsw_tb.sv
// Testbench: AXI4-Lite drives the host end, which talks to the device end.
// Assumes the host register map and op codes of fsw_pkg.
`timescale 1ns/1ps
module testbench;
  import fsw_pkg::*;
  logic CLK = 0;
  logic RST_B = 0;
  logic [NPART-1:0] locked = '0;
  logic erase_fail = 0;
  logic [3:0] awaddr = '0;
  logic [3:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NPART-1:0] part_prog;
  int failures = 0;
  int comparisons = 0;
  int mem[int];
  int err[NPART];
  fsw_if bus();
  fsw_device fsw_device_inst (.CLK(CLK), .RST_B(RST_B), .BUS(bus), .LOCKED(locked),
    .ERASE_FAIL(erase_fail), .PART_PROGRAMMING(part_prog), .BUSY(busy));
  fsw_host fsw_host_inst (.CLK(CLK), .RST_B(RST_B), .BUS(bus), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  fsw_sva fsw_sva_inst (.CLK(CLK), .RST_B(RST_B), .ce_b(bus.ce_b), .oe_b(bus.oe_b), .we_b(bus.we_b),
    .dq_h2d_oe(bus.dq_h2d_oe), .dq_d2h_oe(bus.dq_d2h_oe), .standby(bus.standby),
    .PART_PROGRAMMING(part_prog), .BUSY(busy));
  initial forever #20 CLK = ~CLK;
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit b;
    b = 0;
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!b) begin
      @(posedge CLK);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) begin
        b = 1;
        r = bresp;
        bready <= 0;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bit b;
    b = 0;
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!b) begin
      @(posedge CLK);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) begin
        b = 1;
        d = rdata;
        rready <= 0;
      end
    end
  endtask
  // Waits for the host to finish the flash cycle before anything else is sent
  task automatic poll;
    logic [31:0] s;
    s = 32'h1;
    while (s[0] !== 1'b0) rd(HR_STAT, s);
  endtask
  task automatic op(input logic [1:0] o, input int a, input int d);
    logic [1:0] r;
    wr(HR_ADDR, 32'(a), r);
    wr(HR_DATA, 32'(d), r);
    wr(HR_CMD, 32'(o), r);
    poll();
  endtask
  // The array keeps one word per partition
  function automatic int mget(input int a);
    return mem.exists(a >> 14) ? mem[a >> 14] : 32'hFFFF;
  endfunction
  // Host duty: poll status of the target partition until the engine is ready
  task automatic await_ready(input int a);
    logic [31:0] s;
    s = 32'h0;
    while (s[7] !== 1'b1) begin
      op(OP_READ, a, 0);
      rd(HR_DATA, s);
      if (s[7] === 1'b0) chk("pbusy", 16'h0, {15'h0, s[0]});
    end
  endtask
  task automatic pg(input int a, input int d, input bit alt);
    int p;
    p = a >> 14;
    if (alt) begin
      op(OP_WRITE, a, CMD_PROG_ALT);
      op(OP_WRITE, a, d);
    end else op(OP_PROGRAM, a, d);
    await_ready(a);
    if (locked[p]) err[p] |= 32'h02;
    else if (!bus.prog_supply_ok) err[p] |= 32'h08;
    else if (err[p] & 32'h08) err[p] |= 32'h10;
    else mem[a >> 14] = mget(a) & d;
    if (erase_fail) err[p] |= 32'h20;
  endtask
  task automatic sts(input int a, input logic [15:0] m);
    logic [31:0] s;
    op(OP_READ, a, 0);
    rd(HR_DATA, s);
    chk("status", 16'(32'h80 | err[a >> 14]) & m, s[15:0] & m);
  endtask
  task automatic arr(input int a);
    logic [31:0] s;
    op(OP_WRITE, a, CMD_READ_ARRAY);
    op(OP_READ, a, 0);
    rd(HR_DATA, s);
    chk("array", 16'(mget(a)), s[15:0]);
  endtask
  task automatic rst;
    RST_B <= 0;
    repeat (4) @(posedge CLK);
    RST_B <= 1;
    mem.delete();
    err = '{default: 0};
  endtask
  initial begin
    repeat (80000) @(posedge CLK);
    failures++;
    summarize();
  end
  initial begin
    int a;
    logic [1:0] r;
    bus.prog_supply_ok <= 1;
    void'($urandom(32'hc536));
    rst();
    for (int p = 0; p < NPART; p++) begin
      a = (p << 14) | ($urandom & 32'h3FFF);
      pg(a, $urandom & 32'hFFFF, p[0]);
      sts(a, 16'hFFFF);
      pg(a, $urandom & 32'hFFFF, 0);
      arr(a);
    end
    $display("test program done");
    a = 32'h0123;
    wr(HR_ADDR, 32'(a), r);
    wr(HR_DATA, 32'h00F0, r);
    wr(HR_CMD, 32'(OP_PROGRAM), r);
    wr(HR_CMD, 32'(OP_PROGRAM), r);
    chk("bresp", 16'h2, 16'(r));
    poll();
    op(OP_WRITE, a, CMD_READ_STATUS);
    await_ready(a);
    mem[a >> 14] = mget(a) & 32'h00F0;
    arr(a);
    $display("test busy done");
    locked[1] <= 1;
    a = 32'h4055;
    pg(a, 32'h0000, 0);
    sts(a, 16'hFFFF);
    op(OP_WRITE, a, CMD_READ_STATUS);
    sts(a, 16'hFFFF);
    op(OP_WRITE, a, CMD_CLEAR_STATUS);
    err[1] = 0;
    sts(a, 16'hFFFF);
    locked[1] <= 0;
    arr(a);
    $display("test lock done");
    a = 32'h8077;
    bus.prog_supply_ok <= 0;
    pg(a, 32'h1234, 0);
    sts(a, 16'h0008);
    bus.prog_supply_ok <= 1;
    pg(a, 32'h0000, 0);
    arr(a);
    op(OP_WRITE, a, CMD_CLEAR_STATUS);
    err[2] = 0;
    pg(a, 32'h0F0F, 0);
    sts(a, 16'h0010);
    arr(a);
    $display("test supply done");
    erase_fail <= 1;
    pg(a, 32'h0F00, 0);
    erase_fail <= 0;
    sts(a, 16'h0020);
    $display("test fail flag done");
    locked[3] <= 1;
    pg(32'hC001, 32'h0000, 0);
    locked[3] <= 0;
    rst();
    op(OP_WRITE, 32'hC001, CMD_READ_STATUS);
    sts(32'hC001, 16'hFFFF);
    arr(32'hC001);
    $display("test reset done");
    summarize();
  end
endmodule
